// file: rtl/bpfc_top.sv
`timescale 1ns/1ns
module bpfc_top #(
   parameter int TICK_CYCLES = bpfc_pkg::TIMEBASE_CYCLES
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic overvolt_detect,
   input wire logic thermal_detect,
   input wire logic ilim_detect,
   input wire logic diode_open_detect,
   input wire logic undervoltage_lockout,
   input wire logic comp_above_threshold,
   input wire logic switch_cycle_start,
   output logic converter_enable,
   output logic converter_standby,
   output logic converter_shutdown,
   output logic switch_blank,
   output logic current_sink_ports_off,
   output logic ref_full_select,
   output logic min_duty_hold
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
      addr_hit = (a == target);
   endfunction

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [bpfc_pkg::SYNC_INPUTS-1:0] raw_in;
   logic [bpfc_pkg::SYNC_INPUTS-1:0] meta_r;
   logic [bpfc_pkg::SYNC_INPUTS-1:0] sync_r;
   logic [bpfc_pkg::SYNC_INPUTS-1:0] prev_r;
   assign raw_in = {switch_cycle_start, comp_above_threshold, undervoltage_lockout,
                    diode_open_detect, ilim_detect, overvolt_detect};
   genvar gi;
   generate
      for (gi = 0; gi < bpfc_pkg::SYNC_INPUTS; gi++) begin : g_sync
         always_ff @(posedge clock) begin
            if (reset) begin
               meta_r[gi] <= 1'b0;
               sync_r[gi] <= 1'b0;
               prev_r[gi] <= 1'b0;
            end else begin
               meta_r[gi] <= raw_in[gi];
               sync_r[gi] <= meta_r[gi];
               prev_r[gi] <= sync_r[gi];
            end
         end
      end
   endgenerate
   logic th_meta_r;
   logic th_sync_r;
   logic th_prev_r;
   always_ff @(posedge clock) begin
      if (reset) begin
         th_meta_r <= 1'b0;
         th_sync_r <= 1'b0;
         th_prev_r <= 1'b0;
      end else begin
         th_meta_r <= thermal_detect;
         th_sync_r <= th_meta_r;
         th_prev_r <= th_sync_r;
      end
   end
   wire ov_s = sync_r[0];
   wire ilim_s = sync_r[1];
   wire diode_s = sync_r[2];
   wire undervoltage_lockout_s = sync_r[3];
   wire comp_s = sync_r[4];
   wire ov_rise = sync_r[0] & ~prev_r[0];
   wire ov_fall = ~sync_r[0] & prev_r[0];
   wire cyc_start = sync_r[5] & ~prev_r[5];
   wire th_s = th_sync_r;
   wire th_rise = th_sync_r & ~th_prev_r;
   wire th_fall = ~th_sync_r & th_prev_r;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   wire wr_cfg = reg_write & addr_hit(reg_addr, bpfc_pkg::ADDR_CONFIG);
   wire wr_dhi = reg_write & addr_hit(reg_addr, bpfc_pkg::ADDR_DUTY_HIGH);
   wire wr_dlo = reg_write & addr_hit(reg_addr, bpfc_pkg::ADDR_DUTY_LOW);
   wire wr_st = reg_write & addr_hit(reg_addr, bpfc_pkg::ADDR_STATUS);
   wire rd_st = reg_read & addr_hit(reg_addr, bpfc_pkg::ADDR_STATUS);

   logic cfg_en_r, cfg_en_nxt;
   logic cfg_ref_r;
   logic [7:0] duty_hi_r;
   logic [1:0] duty_lo_r;
   logic standby_r, standby_nxt;
   logic ov_flag_r, ov_flag_nxt;
   logic th_flag_r, th_flag_nxt;
   logic ilim_flag_r, ilim_flag_nxt;
   logic blank_r, blank_nxt;

   // Enable: lockout and the start or end of overheating win over software
   assign cfg_en_nxt = undervoltage_lockout_s ? 1'b0 :
                       th_rise ? 1'b0 :
                       th_fall ? 1'b1 :
                       wr_cfg ? reg_wdata[bpfc_pkg::CFG_ENABLE_BIT] : cfg_en_r;
   assign standby_nxt = (ov_rise | th_rise) ? 1'b1 :
                        (ov_fall | th_fall) ? 1'b0 :
                        wr_st ? reg_wdata[bpfc_pkg::ST_STANDBY_BIT] : standby_r;
   // Faults: set wins over read-clear
   assign ov_flag_nxt = ov_s ? 1'b1 : (ov_fall | rd_st) ? 1'b0 : ov_flag_r;
   assign th_flag_nxt = th_s ? 1'b1 : rd_st ? 1'b0 : th_flag_r;
   wire ilim_event = ilim_s & converter_enable;
   assign ilim_flag_nxt = ilim_event ? 1'b1 : rd_st ? 1'b0 : ilim_flag_r;
   assign blank_nxt = ilim_event ? 1'b1 : cyc_start ? 1'b0 : blank_r;

   always_ff @(posedge clock) begin
      if (reset) begin
         cfg_en_r <= bpfc_pkg::CONFIG_RESET[bpfc_pkg::CFG_ENABLE_BIT];
         cfg_ref_r <= bpfc_pkg::CONFIG_RESET[bpfc_pkg::CFG_REF_FULL_BIT];
         duty_hi_r <= bpfc_pkg::DUTY_HIGH_RESET;
         duty_lo_r <= bpfc_pkg::DUTY_LOW_RESET;
         standby_r <= bpfc_pkg::STANDBY_RESET;
         ov_flag_r <= 1'b0;
         th_flag_r <= 1'b0;
         ilim_flag_r <= 1'b0;
         blank_r <= 1'b0;
      end else begin
         cfg_en_r <= cfg_en_nxt;
         if (wr_cfg) begin
            cfg_ref_r <= reg_wdata[bpfc_pkg::CFG_REF_FULL_BIT];
         end
         if (wr_dhi) begin
            duty_hi_r <= reg_wdata;
         end
         if (wr_dlo) begin
            duty_lo_r <= reg_wdata[bpfc_pkg::DUTY_LOW_BITS-1:0];
         end
         standby_r <= standby_nxt;
         ov_flag_r <= ov_flag_nxt;
         th_flag_r <= th_flag_nxt;
         ilim_flag_r <= ilim_flag_nxt;
         blank_r <= blank_nxt;
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   wire [7:0] cfg_view = {cfg_ref_r, 6'h00, cfg_en_r};
   wire [7:0] status_view = {3'h0, diode_s, ilim_flag_r, th_flag_r, ov_flag_r, standby_r};
   wire [7:0] rd_mux =
      addr_hit(reg_addr, bpfc_pkg::ADDR_CONFIG) ? cfg_view :
      addr_hit(reg_addr, bpfc_pkg::ADDR_DUTY_HIGH) ? duty_hi_r :
      addr_hit(reg_addr, bpfc_pkg::ADDR_DUTY_LOW) ? {6'h00, duty_lo_r} :
      addr_hit(reg_addr, bpfc_pkg::ADDR_STATUS) ? status_view : 8'h00;
   always_ff @(posedge clock) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
         if (reg_read) begin
            reg_rdata <= rd_mux;
         end
      end
   end

   // ----------------------------------------
   // Timebase and modulator
   // ----------------------------------------
   logic [15:0] div_r;
   logic [bpfc_pkg::PWM_BITS-1:0] pwm_cnt_r;
   wire tick = (div_r == 16'(TICK_CYCLES - 1));
   always_ff @(posedge clock) begin
      if (reset) begin
         div_r <= 16'h0000;
         pwm_cnt_r <= '0;
      end else begin
         div_r <= tick ? 16'h0000 : div_r + 16'h0001;
         if (tick) begin
            pwm_cnt_r <= pwm_cnt_r + 10'h001;
         end
      end
   end
   wire [bpfc_pkg::PWM_BITS-1:0] duty = {duty_hi_r, duty_lo_r};
   wire duty_zero = (duty == 10'h000);
   wire pwm_on = (pwm_cnt_r < duty);

   // ----------------------------------------
   // Converter control
   // ----------------------------------------
   wire shut = ~cfg_en_r | standby_r | undervoltage_lockout_s;
   assign converter_shutdown = shut;
   assign converter_standby = ~shut & duty_zero;
   assign converter_enable = ~shut & pwm_on & ~blank_r;
   assign switch_blank = blank_r;
   assign current_sink_ports_off = th_s;
   assign ref_full_select = cfg_ref_r;

   // ----------------------------------------
   // Quick start
   // ----------------------------------------
   bpfc_pkg::bpfc_qs_e qs_r, qs_nxt;
   always_comb begin
      qs_nxt = qs_r;
      case (qs_r)
         bpfc_pkg::QS_OFF: begin
            if (!shut) begin
               qs_nxt = bpfc_pkg::QS_CHARGE;
            end
         end
         bpfc_pkg::QS_CHARGE: begin
            if (shut) begin
               qs_nxt = bpfc_pkg::QS_OFF;
            end else if (comp_s) begin
               qs_nxt = bpfc_pkg::QS_RUN;
            end
         end
         bpfc_pkg::QS_RUN: begin
            if (shut) begin
               qs_nxt = bpfc_pkg::QS_OFF;
            end
         end
         default: begin
            qs_nxt = bpfc_pkg::QS_OFF;
         end
      endcase
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         qs_r <= bpfc_pkg::QS_OFF;
      end else begin
         qs_r <= qs_nxt;
      end
   end
   assign min_duty_hold = (qs_r == bpfc_pkg::QS_CHARGE);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_shutdown_gates_enable: assert property (
      @(posedge clock) disable iff (reset) (!cfg_en_r || standby_r) |-> !converter_enable)
      else $error("converter enabled while shut down");
   a_zero_duty_off: assert property (
      @(posedge clock) disable iff (reset) duty_zero |-> !converter_enable)
      else $error("converter switching with zero duty");
   a_counter_steps: assert property (
      @(posedge clock) disable iff (reset) tick |=> pwm_cnt_r == $past(pwm_cnt_r) + 10'h001)
      else $error("modulator counter did not advance on tick");
   a_ov_standby: assert property (
      @(posedge clock) disable iff (reset) ov_rise |=> standby_r && ov_flag_r)
      else $error("overvoltage did not force standby");
   a_ov_release: assert property (
      @(posedge clock) disable iff (reset) (ov_fall && !th_rise) |=> !standby_r && !ov_flag_r)
      else $error("overvoltage end did not resume");
   a_read_clears: assert property (
      @(posedge clock) disable iff (reset) (rd_st && !ilim_event) |=> !ilim_flag_r)
      else $error("status read did not clear current limit");
   a_thermal_entry: assert property (
      @(posedge clock) disable iff (reset) th_rise |=> standby_r && !cfg_en_r && th_flag_r)
      else $error("thermal entry incomplete");
   a_ilim_blank: assert property (
      @(posedge clock) disable iff (reset) ilim_event |=> blank_r && !converter_enable)
      else $error("current limit did not blank switch");
   a_undervoltage_lockout_clears: assert property (
      @(posedge clock) disable iff (reset) undervoltage_lockout_s |=> !cfg_en_r ##0 !converter_enable)
      else $error("lockout did not clear enable");
   a_quick_hold: assert property (
      @(posedge clock) disable iff (reset)
      (qs_r == bpfc_pkg::QS_CHARGE && comp_s && !shut) |=> !min_duty_hold)
      else $error("quick start did not release");
   c_pwm_active: cover property (@(posedge clock) disable iff (reset) $rose(converter_enable));
   c_thermal_cycle: cover property (@(posedge clock) disable iff (reset) th_rise ##[1:50] th_fall);
   c_ilim_hit: cover property (@(posedge clock) disable iff (reset) ilim_event ##[1:50] cyc_start);
   c_quick_done: cover property (@(posedge clock) disable iff (reset)
      qs_r == bpfc_pkg::QS_CHARGE ##1 qs_r == bpfc_pkg::QS_RUN);
endmodule // bpfc_top

// file: rtl/bpfc_pkg.sv
package bpfc_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_CONFIG = 8'h10;
   localparam logic [7:0] ADDR_DUTY_HIGH = 8'h20;
   localparam logic [7:0] ADDR_DUTY_LOW = 8'h21;
   localparam logic [7:0] ADDR_STATUS = 8'h22;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CFG_ENABLE_BIT = 0;
   localparam int CFG_REF_FULL_BIT = 7;
   localparam int ST_STANDBY_BIT = 0;
   localparam int ST_OVERVOLT_BIT = 1;
   localparam int ST_THERMAL_BIT = 2;
   localparam int ST_ILIM_BIT = 3;
   localparam int ST_DIODE_OPEN_BIT = 4;
   localparam int DUTY_LOW_BITS = 2;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] DUTY_HIGH_RESET = 8'h00;
   localparam logic [1:0] DUTY_LOW_RESET = 2'h0;
   localparam logic STANDBY_RESET = 1'b1;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int TIMEBASE_PERIOD_NS = 8000;
   localparam int TIMEBASE_CYCLES = TIMEBASE_PERIOD_NS / CLOCK_PERIOD_NS;
   localparam int PWM_BITS = 10;
   localparam int PWM_PERIOD_TICKS = 1024;
   localparam int PWM_PERIOD_US = 8192;
   localparam int SYNC_INPUTS = 6;
   // ----------------------------------------
   // Quick-start states
   // ----------------------------------------
   typedef enum logic [1:0] {QS_OFF, QS_CHARGE, QS_RUN} bpfc_qs_e;
endpackage

// file: test/bpfc_host_model.sv
`timescale 1ns/1ns
module bpfc_host_model (
   input wire logic clock,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_write,
   output logic reg_read
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   // ----------------------------------------
   // Register access
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      int i;
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      ok = 1'b0;
      d = 8'h00;
      for (i = 0; i < 4 && !ok; i++) begin
         #1;
         if (reg_rvalid === 1'b1) begin
            ok = 1'b1;
            d = reg_rdata;
         end else begin
            @(posedge clock);
         end
      end
   endtask
endmodule // bpfc_host_model

// file: test/boost_pwm_fault_control_test.sv
`timescale 1ns/1ns
module boost_pwm_fault_control_test;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_write, reg_read, reg_rvalid;
   logic overvolt_detect = 1'b0;
   logic thermal_detect = 1'b0;
   logic ilim_detect = 1'b0;
   logic diode_open_detect = 1'b0;
   logic undervoltage_lockout = 1'b0;
   logic comp_above_threshold = 1'b0;
   logic switch_cycle_start = 1'b0;
   logic converter_enable, converter_standby, converter_shutdown, switch_blank;
   logic current_sink_ports_off, ref_full_select, min_duty_hold;
   logic [31:0] seed = 32'h67c371fa;
   int err_total = 0;
   int total_checks = 0;
   always #5 clock = ~clock;
   // ----------------------------------------
   // Reference modulator model
   // ----------------------------------------
   localparam int TB_TICK = 4;
   int mdl_div = 0;
   int mdl_cnt = 0;
   always @(posedge clock) begin
      if (reset) begin
         mdl_div <= 0;
         mdl_cnt <= 0;
      end else if (mdl_div == TB_TICK - 1) begin
         mdl_div <= 0;
         mdl_cnt <= (mdl_cnt + 1) % bpfc_pkg::PWM_PERIOD_TICKS;
      end else begin
         mdl_div <= mdl_div + 1;
      end
   end
   bpfc_top #(.TICK_CYCLES(TB_TICK)) bpfc_top_i (.clock(clock), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .overvolt_detect(overvolt_detect), .thermal_detect(thermal_detect),
      .ilim_detect(ilim_detect), .diode_open_detect(diode_open_detect),
      .undervoltage_lockout(undervoltage_lockout),
      .comp_above_threshold(comp_above_threshold),
      .switch_cycle_start(switch_cycle_start), .converter_enable(converter_enable),
      .converter_standby(converter_standby), .converter_shutdown(converter_shutdown),
      .switch_blank(switch_blank), .current_sink_ports_off(current_sink_ports_off),
      .ref_full_select(ref_full_select), .min_duty_hold(min_duty_hold));
   bpfc_host_model bpfc_host_model_i (.clock(clock), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read));
   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic chk_cnt(input string n, input int e, input int g);
      total_checks++;
      if (g != e) begin
         err_total++;
         $display("ERROR %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      bpfc_host_model_i.rd(a, d, ok);
      if (!ok) begin
         err_total++;
         $display("ERROR reg_rvalid expected 1 seen 0");
      end else begin
         chk_reg("reg_rdata", e, d);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic set_duty(input logic [9:0] d, input logic [5:0] junk);
      bpfc_host_model_i.wr(bpfc_pkg::ADDR_DUTY_HIGH, d[9:2]);
      bpfc_host_model_i.wr(bpfc_pkg::ADDR_DUTY_LOW, {junk, d[1:0]});
      rchk(bpfc_pkg::ADDR_DUTY_HIGH, d[9:2]);
      rchk(bpfc_pkg::ADDR_DUTY_LOW, {6'h00, d[1:0]});
   endtask
   task automatic pwm_chk(input int duty);
      int n;
      int mism;
      n = 0;
      mism = 0;
      tick(1);
      repeat (4096) begin
         n += (converter_enable === 1'b1);
         mism += (converter_enable !== (mdl_cnt < duty));
         tick(1);
      end
      chk_cnt("enable_ticks", duty * TB_TICK, n);
      chk_cnt("enable_vs_model", 0, mism);
      chk_bit("converter_standby", duty == 0, converter_standby);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [9:0] d;
      int i;
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      rchk(bpfc_pkg::ADDR_STATUS, 8'h01);
      rchk(bpfc_pkg::ADDR_DUTY_HIGH, 8'h00);
      rchk(8'h33, 8'h00);
      chk_bit("converter_shutdown", 1'b1, converter_shutdown);
      bpfc_host_model_i.wr(bpfc_pkg::ADDR_CONFIG, 8'h81);
      bpfc_host_model_i.wr(bpfc_pkg::ADDR_STATUS, 8'hfe);
      rchk(bpfc_pkg::ADDR_STATUS, 8'h00);
      tick(2);
      chk_bit("converter_shutdown", 1'b0, converter_shutdown);
      chk_bit("ref_full_select", 1'b1, ref_full_select);
      chk_bit("min_duty_hold", 1'b1, min_duty_hold);
      comp_above_threshold <= 1'b1;
      tick(5);
      chk_bit("min_duty_hold", 1'b0, min_duty_hold);
      for (i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         d = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : seed[9:0];
         set_duty(d, seed[15:10]);
         pwm_chk(d);
      end
      overvolt_detect <= 1'b1;
      tick(5);
      chk_bit("converter_shutdown", 1'b1, converter_shutdown);
      rchk(bpfc_pkg::ADDR_STATUS, 8'h03);
      rchk(bpfc_pkg::ADDR_STATUS, 8'h03);
      overvolt_detect <= 1'b0;
      tick(5);
      rchk(bpfc_pkg::ADDR_STATUS, 8'h00);
      chk_bit("converter_shutdown", 1'b0, converter_shutdown);
      comp_above_threshold <= 1'b0;
      thermal_detect <= 1'b1;
      tick(5);
      chk_bit("current_sink_ports_off", 1'b1, current_sink_ports_off);
      rchk(bpfc_pkg::ADDR_STATUS, 8'h05);
      rchk(bpfc_pkg::ADDR_CONFIG, 8'h80);
      thermal_detect <= 1'b0;
      tick(5);
      rchk(bpfc_pkg::ADDR_CONFIG, 8'h81);
      chk_bit("current_sink_ports_off", 1'b0, current_sink_ports_off);
      chk_bit("min_duty_hold", 1'b1, min_duty_hold);
      rchk(bpfc_pkg::ADDR_STATUS, 8'h04);
      rchk(bpfc_pkg::ADDR_STATUS, 8'h00);
      comp_above_threshold <= 1'b1;
      set_duty(10'h3ff, 6'h3f);
      for (i = 0; i < 5000 && converter_enable === 1'b1; i++) tick(1);
      for (i = 0; i < 5000 && converter_enable !== 1'b1; i++) tick(1);
      chk_bit("converter_enable", 1'b1, converter_enable);
      ilim_detect <= 1'b1;
      tick(4);
      ilim_detect <= 1'b0;
      chk_bit("switch_blank", 1'b1, switch_blank);
      chk_bit("converter_enable", 1'b0, converter_enable);
      rchk(bpfc_pkg::ADDR_STATUS, 8'h08);
      switch_cycle_start <= 1'b1;
      tick(5);
      switch_cycle_start <= 1'b0;
      chk_bit("switch_blank", 1'b0, switch_blank);
      diode_open_detect <= 1'b1;
      tick(5);
      rchk(bpfc_pkg::ADDR_STATUS, 8'h10);
      diode_open_detect <= 1'b0;
      undervoltage_lockout <= 1'b1;
      ilim_detect <= 1'b1;
      tick(5);
      chk_bit("converter_shutdown", 1'b1, converter_shutdown);
      undervoltage_lockout <= 1'b0;
      ilim_detect <= 1'b0;
      tick(5);
      chk_bit("switch_blank", 1'b0, switch_blank);
      rchk(bpfc_pkg::ADDR_CONFIG, 8'h80);
      rchk(bpfc_pkg::ADDR_STATUS, 8'h00);
      bpfc_host_model_i.wr(bpfc_pkg::ADDR_CONFIG, 8'h01);
      rchk(bpfc_pkg::ADDR_CONFIG, 8'h01);
      chk_bit("ref_full_select", 1'b0, ref_full_select);
      final_report();
   end
endmodule // boost_pwm_fault_control_test
